// file: core/ins_seq_pkg.sv
// package: register map, field layouts, timing constants and carrier types of the sequencer
package ins_seq_pkg;
   // clock and timing
   localparam int unsigned CLK_HZ = 25_000_000;
   localparam int unsigned READY_WINDOW_MS = 1000;
   localparam int unsigned READY_CYCLES = CLK_HZ / 1000 * READY_WINDOW_MS;
   localparam int unsigned MS_CYCLES = CLK_HZ / 1000;
   localparam int unsigned TENTH_S_MS = 100;
   localparam logic [13:0] ELAPSED_MAX = 14'h270F;  // 999.9 s in tenths
   localparam logic [15:0] NOTICE_UNARMED = 16'h0066;  // notice 102
   localparam int unsigned MEM_DEPTH = 999;
   // register byte offsets
   localparam logic [11:0] A_CTRL = 12'h000;
   localparam logic [11:0] A_CMD = 12'h004;
   localparam logic [11:0] A_TTIME = 12'h008;
   localparam logic [11:0] A_STATUS = 12'h00C;
   localparam logic [11:0] A_TIMER = 12'h010;
   localparam logic [11:0] A_COUNT = 12'h014;
   localparam logic [11:0] A_RIDX = 12'h018;
   localparam logic [11:0] A_RDATA = 12'h01C;
   localparam logic [11:0] A_FIELD = 12'h020;
   localparam logic [11:0] A_NOTICE = 12'h024;
   // control bits
   localparam int unsigned C_TIMER_EN = 0;
   localparam int unsigned C_COMP_EN = 1;
   localparam int unsigned C_PASS_STOP = 2;
   localparam int unsigned C_FAIL_STOP = 3;
   localparam int unsigned C_CONTACT_EN = 4;
   localparam int unsigned C_BDD_STOP = 5;
   localparam int unsigned C_AUTO_RANGE = 6;
   // command bits, write one to act
   localparam int unsigned K_ARM = 0;
   localparam int unsigned K_START = 1;
   localparam int unsigned K_HALT = 2;
   localparam int unsigned K_NOTICE_CLR = 3;
   // reset values
   localparam logic [6:0] CTRL_RST = 7'h01;
   localparam logic [13:0] TTIME_RST = 14'h000A;
   localparam logic [2:0] FIELD_RST = 3'h0;
   // sequencer states
   typedef enum logic [1:0] {
      ST_IDLE = 2'b00,
      ST_READY = 2'b01,
      ST_RUN = 2'b10
   } seq_state_t;
   // one stored result
   typedef struct packed {
      logic [19:0] stamp_ms;
      logic [3:0] status;
      logic [31:0] resist;
      logic [1:0] judge;
      logic [15:0] volt;
      logic [15:0] curr;
      logic [7:0] bdd_cnt;
      logic contact;
   } record_t;
   // sample from the measurement front end
   typedef struct packed {
      logic valid;
      logic range_settled;
      logic overflow;
      logic underflow;
      logic pass;
      logic fail;
      logic contact_fail;
      logic [31:0] resist;
      logic [15:0] volt;
      logic [15:0] curr;
      logic [7:0] bdd_cnt;
   } meas_t;
endpackage

// file: core/ins_seq.sv
// insulation test sequencer: arming, run timing, end conditions, result memory, apb slave
//////////////////////////////////////////////////////////////////////////////
// Overview of operation
// - stop press while idle arms and shows ready for one second
// - start press inside the ready window begins the test
// - unarmed start beeps and raises notice 102, no test
// - keys, control port and host commands all start and end tests
// - start refused while stop held, external stop on, or interlock active
// - timer on: apply voltage and count down from set time
// - delay marker shown while comparator hold runs, any hold mode
// - timer on: measure until expiry, then show final value
// - timer off: apply voltage, count elapsed time up until stop
// - elapsed counter stops at 999.9 s, measurement continues
// - comparator enabled gives pass or fail per test mode
// - values beyond display range flagged overflow or underflow
// - auto range never settled means no value shown
// - store up to 999 records per test, drop the rest
// - record holds ms stamp, status, values, judgment, breakdown, contact
// - host reads count, records and selects returned field
// - record count cleared at power up and at each test start
// - stop key, external stop, expiry, halt command or interlock end test
// - pass stop ends on pass, fail stop ends on fail
// - contact check fail ends the test
// - breakdown stop ends test once count reaches one
// - indicator dim during discharge, off below about one volt
//////////////////////////////////////////////////////////////////////////////
module ins_seq #(
   parameter int unsigned READY_CNT = ins_seq_pkg::READY_CYCLES,
   parameter int unsigned MS_CNT = ins_seq_pkg::MS_CYCLES
) (
   input wire logic CLOCK,
   input wire logic RESET,
   input wire logic PSEL,
   input wire logic PENABLE,
   input wire logic PWRITE,
   input wire logic [11:0] PADDR,
   input wire logic [31:0] PWDATA,
   output logic [31:0] PRDATA,
   output logic PREADY,
   output logic PSLVERR,
   input wire logic KEY_START,
   input wire logic KEY_STOP,
   input wire logic EXT_START,
   input wire logic EXT_STOP,
   input wire logic INTERLOCK,
   input wire logic HOLD_ACTIVE,
   input wire logic DISCHARGED,
   input wire ins_seq_pkg::meas_t MEAS,
   output logic HV_ON,
   output logic READY_SHOWN,
   output logic DELAY_MARK,
   output logic TEST_LAMP_ON,
   output logic TEST_LAMP_DIM,
   output logic BEEP,
   output logic VALUE_SHOWN,
   output logic OVER_FLAG,
   output logic UNDER_FLAG,
   output logic JUDGE_PASS,
   output logic JUDGE_FAIL,
   output logic [31:0] SHOWN_RESIST,
   output logic [13:0] TIMER_SHOWN
);
   import ins_seq_pkg::*;

   // pin synchronisers: three stages, change taken when stages two and three agree
   // bounces shorter than two cycles are swallowed by the agree filter
   logic [2:0] s_kstart_r, s_kstop_r, s_estart_r, s_estop_r, s_ilock_r;
   logic kstart_r, kstop_r, estart_r, estop_r, ilock_r;
   logic kstart_d_r, kstop_d_r, estart_d_r, estop_d_r;
   always_ff @(posedge CLOCK or posedge RESET) begin
      if (RESET) begin
         s_kstart_r <= 3'h0;
         s_kstop_r <= 3'h0;
         s_estart_r <= 3'h0;
         s_estop_r <= 3'h0;
         s_ilock_r <= 3'h0;
      end else begin
         s_kstart_r <= {s_kstart_r[1:0], KEY_START};
         s_kstop_r <= {s_kstop_r[1:0], KEY_STOP};
         s_estart_r <= {s_estart_r[1:0], EXT_START};
         s_estop_r <= {s_estop_r[1:0], EXT_STOP};
         s_ilock_r <= {s_ilock_r[1:0], INTERLOCK};
      end
   end

   // filtered levels and their previous values for edge detection
   always_ff @(posedge CLOCK or posedge RESET) begin
      if (RESET) begin
         kstart_r <= 1'b0;
         kstop_r <= 1'b0;
         estart_r <= 1'b0;
         estop_r <= 1'b0;
         ilock_r <= 1'b0;
         kstart_d_r <= 1'b0;
         kstop_d_r <= 1'b0;
         estart_d_r <= 1'b0;
         estop_d_r <= 1'b0;
      end else begin
         if (s_kstart_r[1] == s_kstart_r[2]) kstart_r <= s_kstart_r[2];
         if (s_kstop_r[1] == s_kstop_r[2]) kstop_r <= s_kstop_r[2];
         if (s_estart_r[1] == s_estart_r[2]) estart_r <= s_estart_r[2];
         if (s_estop_r[1] == s_estop_r[2]) estop_r <= s_estop_r[2];
         if (s_ilock_r[1] == s_ilock_r[2]) ilock_r <= s_ilock_r[2];
         kstart_d_r <= kstart_r;
         kstop_d_r <= kstop_r;
         estart_d_r <= estart_r;
         estop_d_r <= estop_r;
      end
   end

   // apb decode
   // only full-word addresses decode; other byte offsets are unmapped
   wire apb_acc = PSEL & PENABLE;
   wire apb_wr = apb_acc & PWRITE;
   wire apb_rd = apb_acc & ~PWRITE;
   wire wr_ctrl = apb_wr & (PADDR == A_CTRL);
   wire wr_cmd = apb_wr & (PADDR == A_CMD);
   wire wr_ttime = apb_wr & (PADDR == A_TTIME);
   wire wr_ridx = apb_wr & (PADDR == A_RIDX);
   wire wr_field = apb_wr & (PADDR == A_FIELD);
   wire addr_ok = (PADDR == A_CTRL) | (PADDR == A_CMD) | (PADDR == A_TTIME) |
                  (PADDR == A_STATUS) | (PADDR == A_TIMER) | (PADDR == A_COUNT) |
                  (PADDR == A_RIDX) | (PADDR == A_RDATA) | (PADDR == A_FIELD) |
                  (PADDR == A_NOTICE);

   // request sources from keys, control port and host
   // host commands skip the filter, so they act a few cycles sooner than keys
   wire host_arm = wr_cmd & PWDATA[K_ARM];
   wire host_start = wr_cmd & PWDATA[K_START];
   wire host_halt = wr_cmd & PWDATA[K_HALT];
   wire stop_press = (kstop_r & ~kstop_d_r) | host_arm;
   wire start_press = (kstart_r & ~kstart_d_r) | (estart_r & ~estart_d_r) | host_start;
   wire start_block = kstop_r | estop_r | ilock_r;

   // configuration registers
   // command bits are strobes and never stored; only settings persist
   logic [6:0] ctrl_r;
   logic [13:0] ttime_r;
   logic [2:0] field_r;
   logic [9:0] ridx_r;
   always_ff @(posedge CLOCK or posedge RESET) begin
      if (RESET) begin
         ctrl_r <= CTRL_RST;
         ttime_r <= TTIME_RST;
         field_r <= FIELD_RST;
         ridx_r <= 10'h000;
      end else begin
         if (wr_ctrl) ctrl_r <= PWDATA[6:0];
         if (wr_ttime) ttime_r <= PWDATA[13:0];
         if (wr_field) field_r <= PWDATA[2:0];
         if (wr_ridx) ridx_r <= PWDATA[9:0];
      end
   end

   // sequencer state and timing
   seq_state_t state_r, state_nxt;
   localparam int unsigned RDY_W = $clog2(READY_CNT + 1);
   logic [RDY_W-1:0] rdy_cnt_r;
   logic [$clog2(MS_CNT+1)-1:0] ms_div_r;
   logic [6:0] tenth_r;
   logic [19:0] ms_r;
   logic [13:0] timer_r;
   wire running = (state_r == ST_RUN);
   wire ms_tick = running & (ms_div_r == MS_CNT[$bits(ms_div_r)-1:0] - 1'b1);
   wire tenth_tick = ms_tick & (tenth_r == 7'(TENTH_S_MS - 1));
   wire rdy_expire = (state_r == ST_READY) & (rdy_cnt_r == '0);
   wire time_up = running & ctrl_r[C_TIMER_EN] & (timer_r == 14'h0000);
   wire armed_start = (state_r == ST_READY) & start_press & ~start_block;
   wire unarmed_start = (state_r == ST_IDLE) & start_press & ~start_block;

   // every ending condition of a running test
   // judgment ends act only on a finalised sample, never on stale flags
   wire judge_stop = MEAS.valid & ctrl_r[C_COMP_EN] &
                     ((ctrl_r[C_PASS_STOP] & MEAS.pass) |
                      (ctrl_r[C_FAIL_STOP] & MEAS.fail));
   wire contact_stop = MEAS.valid & ctrl_r[C_CONTACT_EN] & MEAS.contact_fail;
   wire bdd_stop = MEAS.valid & ctrl_r[C_BDD_STOP] & (MEAS.bdd_cnt != 8'h00);
   wire end_test = running & ((kstop_r & ~kstop_d_r) | estop_r | time_up | host_halt |
                   ilock_r | judge_stop | contact_stop | bdd_stop);

   // next state
   // interlock in the ready window drops the arming, so release cannot start a test
   always_comb begin
      state_nxt = state_r;
      unique case (state_r)
         ST_IDLE: if (stop_press) state_nxt = ST_READY;
         ST_READY: begin
            if (armed_start) state_nxt = ST_RUN;
            else if (rdy_expire | ilock_r) state_nxt = ST_IDLE;
         end
         ST_RUN: if (end_test) state_nxt = ST_IDLE;
         default: state_nxt = ST_IDLE;
      endcase
   end

   // state register, ready window count and run timers
   // timers restart at every start so a stamp never carries over from a run
   always_ff @(posedge CLOCK or posedge RESET) begin
      if (RESET) begin
         state_r <= ST_IDLE;
         rdy_cnt_r <= '0;
         ms_div_r <= '0;
         tenth_r <= 7'h00;
         ms_r <= 20'h00000;
         timer_r <= 14'h0000;
      end else begin
         state_r <= state_nxt;
         if (state_r == ST_IDLE && stop_press) rdy_cnt_r <= RDY_W'(READY_CNT - 1);
         else if (rdy_cnt_r != '0) rdy_cnt_r <= rdy_cnt_r - 1'b1;
         if (armed_start) begin
            ms_div_r <= '0;
            tenth_r <= 7'h00;
            ms_r <= 20'h00000;
            timer_r <= ctrl_r[C_TIMER_EN] ? ttime_r : 14'h0000;
         end else if (running) begin
            ms_div_r <= ms_tick ? '0 : ms_div_r + 1'b1;
            if (ms_tick) begin
               ms_r <= ms_r + 20'h00001;
               tenth_r <= tenth_tick ? 7'h00 : tenth_r + 7'h01;
            end
            if (tenth_tick) begin
               if (ctrl_r[C_TIMER_EN] && timer_r != 14'h0000) timer_r <= timer_r - 14'h0001;
               else if (!ctrl_r[C_TIMER_EN] && timer_r != ELAPSED_MAX) timer_r <= timer_r + 14'h0001;
            end
         end
      end
   end

   // result memory; depth kept in flip-flops, count reset on start
   // once full, later samples still reach the display but are not stored
   record_t mem_r [MEM_DEPTH];
   logic [9:0] count_r;
   wire store = running & MEAS.valid & (count_r != 10'(MEM_DEPTH));
   record_t new_rec;
   assign new_rec = '{stamp_ms: ms_r, status: {MEAS.range_settled, MEAS.overflow,
                      MEAS.underflow, MEAS.contact_fail}, resist: MEAS.resist,
                      judge: {MEAS.fail, MEAS.pass}, volt: MEAS.volt, curr: MEAS.curr,
                      bdd_cnt: MEAS.bdd_cnt, contact: ~MEAS.contact_fail};
   always_ff @(posedge CLOCK or posedge RESET) begin
      if (RESET) count_r <= 10'h000;
      else if (armed_start) count_r <= 10'h000;
      else if (store) count_r <= count_r + 10'h001;
   end

   // entries are qualified by count, so only the write port needs to be clocked here
   genvar gi;
   generate
      for (gi = 0; gi < MEM_DEPTH; gi++) begin : g_mem
         always_ff @(posedge CLOCK) begin
            if (store && count_r == 10'(gi)) mem_r[gi] <= new_rec;
         end
      end
   endgenerate

   // record field selection for host read back
   // reads at or past the count give zero, not entries of an earlier test
   wire idx_ok = (ridx_r < count_r);
   record_t rd_rec;
   assign rd_rec = idx_ok ? mem_r[ridx_r] : '0;
   logic [31:0] field_val;
   always_comb begin
      field_val = 32'h00000000;
      unique case (field_r)
         3'h0: field_val = {12'h000, rd_rec.stamp_ms};
         3'h1: field_val = {28'h0000000, rd_rec.status};
         3'h2: field_val = rd_rec.resist;
         3'h3: field_val = {30'h0, rd_rec.judge};
         3'h4: field_val = {16'h0000, rd_rec.volt};
         3'h5: field_val = {16'h0000, rd_rec.curr};
         3'h6: field_val = {24'h000000, rd_rec.bdd_cnt};
         3'h7: field_val = {31'h0, rd_rec.contact};
      endcase
   end

   // display, judgment and notice; display and judgment frozen once the test ends, notice set on an unarmed start and cleared by command unless set in the same cycle
   logic [15:0] notice_r;
   logic [3:0] beep_r;
   logic settled_r;
   wire notice_clr = wr_cmd & PWDATA[K_NOTICE_CLR];
   always_ff @(posedge CLOCK or posedge RESET) begin
      if (RESET) begin
         notice_r <= 16'h0000;
         settled_r <= 1'b0;
         VALUE_SHOWN <= 1'b0;
         OVER_FLAG <= 1'b0;
         UNDER_FLAG <= 1'b0;
         JUDGE_PASS <= 1'b0;
         JUDGE_FAIL <= 1'b0;
         SHOWN_RESIST <= 32'h00000000;
      end else begin
         if (unarmed_start) notice_r <= NOTICE_UNARMED;
         else if (notice_clr) notice_r <= 16'h0000;
         if (armed_start) begin
            settled_r <= 1'b0;
            VALUE_SHOWN <= 1'b0;
            JUDGE_PASS <= 1'b0;
            JUDGE_FAIL <= 1'b0;
            OVER_FLAG <= 1'b0;
            UNDER_FLAG <= 1'b0;
         end else if (running && MEAS.valid) begin
            if (MEAS.range_settled || !ctrl_r[C_AUTO_RANGE]) begin
               settled_r <= 1'b1;
               SHOWN_RESIST <= MEAS.resist;
               OVER_FLAG <= MEAS.overflow;
               UNDER_FLAG <= MEAS.underflow;
            end
            VALUE_SHOWN <= settled_r | MEAS.range_settled | ~ctrl_r[C_AUTO_RANGE];
            JUDGE_PASS <= ctrl_r[C_COMP_EN] & MEAS.pass;
            JUDGE_FAIL <= ctrl_r[C_COMP_EN] & MEAS.fail;
         end
      end
   end

   // indication outputs; beep is a short burst so a buzzer sees it
   // lamps and voltage follow the next state, so both switch on one edge
   always_ff @(posedge CLOCK or posedge RESET) begin
      if (RESET) begin
         beep_r <= 4'h0;
         HV_ON <= 1'b0;
         READY_SHOWN <= 1'b0;
         DELAY_MARK <= 1'b0;
         TEST_LAMP_ON <= 1'b0;
         TEST_LAMP_DIM <= 1'b0;
         BEEP <= 1'b0;
         TIMER_SHOWN <= 14'h0000;
      end else begin
         beep_r <= unarmed_start ? 4'hF : (beep_r != 4'h0 ? beep_r - 4'h1 : 4'h0);
         BEEP <= (beep_r != 4'h0);
         HV_ON <= (state_nxt == ST_RUN);
         READY_SHOWN <= (state_nxt == ST_READY);
         DELAY_MARK <= (state_nxt == ST_RUN) & HOLD_ACTIVE;
         TEST_LAMP_ON <= (state_nxt == ST_RUN);
         TEST_LAMP_DIM <= (state_nxt != ST_RUN) & (TEST_LAMP_ON | TEST_LAMP_DIM) &
                          ~DISCHARGED;
         TIMER_SHOWN <= timer_r;
      end
   end

   // apb read data; status bits show sequencer state
   logic [31:0] rdata_mux;
   always_comb begin
      rdata_mux = 32'h00000000;
      unique case (PADDR)
         A_CTRL: rdata_mux = {25'h0, ctrl_r};
         A_TTIME: rdata_mux = {18'h0, ttime_r};
         A_STATUS: rdata_mux = {24'h000000, VALUE_SHOWN, JUDGE_FAIL, JUDGE_PASS, UNDER_FLAG,
                                OVER_FLAG, TEST_LAMP_DIM, state_r};
         A_TIMER: rdata_mux = {18'h0, timer_r};
         A_COUNT: rdata_mux = {22'h0, count_r};
         A_RIDX: rdata_mux = {22'h0, ridx_r};
         A_RDATA: rdata_mux = field_val;
         A_FIELD: rdata_mux = {29'h0, field_r};
         A_NOTICE: rdata_mux = {16'h0000, notice_r};
         default: rdata_mux = 32'h00000000;
      endcase
   end

   // zero wait-state slave: answer registered during setup
   // pready is never stretched; a master must not expect more wait states
   always_ff @(posedge CLOCK or posedge RESET) begin
      if (RESET) begin
         PRDATA <= 32'h00000000;
         PREADY <= 1'b0;
         PSLVERR <= 1'b0;
      end else begin
         PREADY <= PSEL & ~PENABLE;
         PSLVERR <= PSEL & ~PENABLE & ~addr_ok;
         PRDATA <= (PSEL & ~PENABLE & ~PWRITE) ? rdata_mux : 32'h00000000;
      end
   end
endmodule

// file: bench/ins_seq_properties.sv
// concurrent checks on the sequencer top-level ports
module ins_seq_properties #(
   parameter int unsigned READY_CNT = 50
) (
   input wire logic CLOCK,
   input wire logic RESET,
   input wire logic INTERLOCK,
   input wire logic EXT_STOP,
   input wire logic HOLD_ACTIVE,
   input wire logic DISCHARGED,
   input wire logic HV_ON,
   input wire logic READY_SHOWN,
   input wire logic DELAY_MARK,
   input wire logic TEST_LAMP_DIM,
   input wire logic BEEP,
   input wire logic JUDGE_PASS,
   input wire logic JUDGE_FAIL,
   input wire logic [31:0] SHOWN_RESIST,
   input wire logic [13:0] TIMER_SHOWN
);
   timeunit 1ns;
   timeprecision 1ns;
   import ins_seq_pkg::*;
   default clocking cb @(posedge CLOCK); endclocking
   default disable iff (RESET);
   int unsigned ready_run_r;
   // length of the ready window; a stuck window would let a late start through
   always_ff @(posedge CLOCK or posedge RESET) begin
      if (RESET) ready_run_r <= 0;
      else ready_run_r <= READY_SHOWN ? ready_run_r + 1 : 0;
   end
   ready_span_a: assert property (ready_run_r <= READY_CNT + 1)
      else $error("ready window overran");
   ready_excl_a: assert property (READY_SHOWN |-> !HV_ON)
      else $error("ready shown with voltage on");
   // held stop sources must cut the voltage after the input filter
   lock_cut_a: assert property (INTERLOCK [*8] |-> ##2 !HV_ON)
      else $error("voltage on under interlock");
   xstop_cut_a: assert property (EXT_STOP [*8] |-> ##2 !HV_ON)
      else $error("voltage on under external stop");
   timer_cap_a: assert property (TIMER_SHOWN <= ELAPSED_MAX)
      else $error("timer beyond saturation");
   judge_one_a: assert property (!(JUDGE_PASS && JUDGE_FAIL))
      else $error("pass and fail together");
   frozen_val_a: assert property ($fell(HV_ON) |=> $stable(SHOWN_RESIST) [*4])
      else $error("display moved after end");
   beep_burst_a: assert property ($rose(BEEP) |-> BEEP [*8])
      else $error("beep burst too short");
   dim_off_a: assert property (TEST_LAMP_DIM |-> !HV_ON)
      else $error("dim lamp during run");
   dim_clear_a: assert property (DISCHARGED [*8] |-> !TEST_LAMP_DIM)
      else $error("dim lamp after discharge");
   mark_off_a: assert property (!HOLD_ACTIVE [*3] |-> !DELAY_MARK)
      else $error("delay marker without hold");
endmodule

// file: bench/panel_model.sv
// operator keys, control port lines and interlock as the far side drives them
module panel_model (
   input wire logic clock,
   output logic key_start,
   output logic key_stop,
   output logic ext_start,
   output logic ext_stop,
   output logic interlock
);
   timeunit 1ns;
   timeprecision 1ns;
   logic [4:0] lines_r = 5'h00;
   // released lines rest low, as the pull-downs leave them
   assign {interlock, ext_stop, ext_start, key_stop, key_start} = lines_r;
   // a press outlasts the input filter so it is never lost
   task press(input int sel);
      @(posedge clock);
      lines_r[sel] <= 1'b1;
      repeat (8) @(posedge clock);
      lines_r[sel] <= 1'b0;
   endtask
   // held levels stay until told otherwise
   task hold(input int sel, input logic v);
      @(posedge clock);
      lines_r[sel] <= v;
   endtask
endmodule

// file: bench/tb.sv
// self-checking bench for the insulation test sequencer
module tb;
   timeunit 1ns;
   timeprecision 1ns;
   import ins_seq_pkg::*;
   localparam int unsigned READY_CNT = 50;
   logic clock = 1'b0;
   logic reset = 1'b1;
   logic psel, penable, pwrite;
   logic [11:0] paddr;
   logic [31:0] pwdata, prdata, q;
   logic pready, pslverr, e, hold_act, dischg;
   logic k_start, k_stop, x_start, x_stop, lock;
   meas_t meas;
   logic hv, rdy, mark, lamp, dim, beep, shown, ovf, unf, jp, jf;
   logic [31:0] resist;
   logic [13:0] timer;
   int n_errors = 0, n_checks = 0;
   always #20 clock = ~clock;
   ins_seq #(.READY_CNT(READY_CNT), .MS_CNT(4)) u_dut (
      .CLOCK(clock), .RESET(reset), .PSEL(psel), .PENABLE(penable), .PWRITE(pwrite),
      .PADDR(paddr), .PWDATA(pwdata), .PRDATA(prdata), .PREADY(pready), .PSLVERR(pslverr),
      .KEY_START(k_start), .KEY_STOP(k_stop), .EXT_START(x_start), .EXT_STOP(x_stop),
      .INTERLOCK(lock), .HOLD_ACTIVE(hold_act), .DISCHARGED(dischg), .MEAS(meas),
      .HV_ON(hv), .READY_SHOWN(rdy), .DELAY_MARK(mark), .TEST_LAMP_ON(lamp),
      .TEST_LAMP_DIM(dim), .BEEP(beep), .VALUE_SHOWN(shown), .OVER_FLAG(ovf),
      .UNDER_FLAG(unf), .JUDGE_PASS(jp), .JUDGE_FAIL(jf), .SHOWN_RESIST(resist),
      .TIMER_SHOWN(timer));
   panel_model u_pm (.clock(clock), .key_start(k_start), .key_stop(k_stop),
      .ext_start(x_start), .ext_stop(x_stop), .interlock(lock));
   ////////////////////////////////////////////////////////////////////////////
   // shared helpers: compare, apb transfer, waits, samples
   task chk(input logic [31:0] got, input logic [31:0] exp);
      n_checks++;
      if (got !== exp) begin
         n_errors++;
         $display("MISMATCH t=%0t got %h exp %h", $time, got, exp);
      end
   endtask
   // pready and read data are taken at the rising edge that completes the access
   task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
      @(posedge clock);
      {psel, pwrite, paddr, pwdata} <= {1'b1, w, a, d};
      @(posedge clock);
      penable <= 1'b1;
      @(posedge clock);
      while (pready !== 1'b1) @(posedge clock);
      q = prdata;
      e = pslverr;
      {psel, penable} <= 2'b00;
   endtask
   task wr(input logic [11:0] a, input logic [31:0] d);
      apb(1'b1, a, d);
   endtask
   task rd(input logic [11:0] a);
      apb(1'b0, a, 32'h0);
   endtask
   task idle(input int n);
      repeat (n) @(negedge clock);
   endtask
   task wait_hv(input logic v, input int n);
      @(negedge clock);
      for (int i = 0; i < n && hv !== v; i++) @(negedge clock);
      chk(hv, v);
   endtask
   task samp(input meas_t m);
      @(posedge clock);
      meas <= m;
      @(posedge clock);
      meas.valid <= 1'b0;
   endtask
   task arm_start();
      u_pm.press(1);
      chk(rdy, 1'b1);
      u_pm.press(0);
      wait_hv(1'b1, 40);
   endtask
   ////////////////////////////////////////////////////////////////////////////
   // scenarios
   task t_unarmed();
      rd(12'hFF0);
      chk(e, 1'b1);
      chk(q, 32'h0);
      u_pm.press(0);
      chk(beep, 1'b1);
      chk(hv, 1'b0);
      rd(A_NOTICE);
      chk(q, {16'h0, NOTICE_UNARMED});
      wr(A_CMD, 32'h8);
      rd(A_NOTICE);
      chk(q, 32'h0);
      u_pm.press(1);
      idle(READY_CNT + 10);
      chk(rdy, 1'b0);
      u_pm.press(0);
      idle(4);
      chk(hv, 1'b0);
      rd(A_NOTICE);
      chk(q, {16'h0, NOTICE_UNARMED});
   endtask
   // timed run of 0.2 s: countdown, hold marker, record readback, expiry
   task t_timed();
      wr(A_TTIME, 32'h2);
      wr(A_CTRL, 32'h1);
      arm_start();
      chk(timer, 14'h2);
      @(posedge clock);
      hold_act <= 1'b1;
      idle(6);
      chk(mark, 1'b1);
      @(posedge clock);
      hold_act <= 1'b0;
      idle(30);
      samp('{valid: 1'b1, range_settled: 1'b1, resist: 32'h1234ABCD, volt: 16'h01F4,
         curr: 16'h0033, default: '0});
      idle(600);
      chk(hv, 1'b1);
      wait_hv(1'b0, 300);
      chk(shown, 1'b1);
      chk(resist, 32'h1234ABCD);
      rd(A_COUNT);
      chk(q, 32'h1);
      wr(A_RIDX, 32'h0);
      wr(A_FIELD, 32'h2);
      rd(A_RDATA);
      chk(q, 32'h1234ABCD);
      wr(A_FIELD, 32'h4);
      rd(A_RDATA);
      chk(q, 32'h1F4);
      wr(A_FIELD, 32'h5);
      rd(A_RDATA);
      chk(q, 32'h33);
      wr(A_FIELD, 32'h0);
      rd(A_RDATA);
      chk(q >= 7 && q <= 12, 1'b1);
   endtask
   // open-ended run from the control port, memory filled past its limit
   task t_count();
      wr(A_CTRL, 32'h0);
      wr(A_CMD, 32'h1);
      u_pm.press(2);
      wait_hv(1'b1, 40);
      idle(1000);
      chk(timer, 14'h2);
      repeat (1000) samp('{valid: 1'b1, range_settled: 1'b1, overflow: 1'b1, default: '0});
      idle(2);
      chk({ovf, unf}, 2'b10);
      samp('{valid: 1'b1, underflow: 1'b1, default: '0});
      idle(2);
      chk({ovf, unf}, 2'b01);
      rd(A_COUNT);
      chk(q, 32'h3E7);
      u_pm.hold(3, 1'b1);
      wait_hv(1'b0, 40);
      u_pm.hold(3, 1'b0);
   endtask
   // host-only run with unsettled auto range, then discharge
   task t_halt();
      wr(A_CTRL, 32'h40);
      wr(A_CMD, 32'h1);
      wr(A_CMD, 32'h2);
      wait_hv(1'b1, 20);
      rd(A_COUNT);
      chk(q, 32'h0);
      samp('{valid: 1'b1, resist: 32'h5, default: '0});
      wr(A_CMD, 32'h4);
      wait_hv(1'b0, 20);
      chk({shown, dim}, 2'b01);
      @(posedge clock);
      dischg <= 1'b1;
      idle(12);
      chk({dim, lamp}, 2'b00);
      @(posedge clock);
      dischg <= 1'b0;
   endtask
   // armed, then a stop source held while start is asked for
   task t_refuse(input int sel);
      wr(A_CMD, 32'h1);
      u_pm.hold(sel, 1'b1);
      idle(6);
      wr(A_CMD, 32'h2);
      idle(8);
      chk(hv, 1'b0);
      u_pm.hold(sel, 1'b0);
      idle(READY_CNT + 5);
   endtask
   // interlock raised in mid-run cuts the voltage
   task t_lock();
      wr(A_CTRL, 32'h0);
      arm_start();
      u_pm.hold(4, 1'b1);
      wait_hv(1'b0, 30);
      u_pm.hold(4, 1'b0);
      idle(8);
   endtask
   task t_end(input logic [31:0] ctrl, input meas_t m);
      wr(A_CTRL, ctrl);
      arm_start();
      if (m.valid) samp(m);
      else u_pm.press(1);
      wait_hv(1'b0, 30);
      chk({jp, jf}, {m.pass & ctrl[1], m.fail & ctrl[1]});
   endtask
   task tally_and_finish();
      if (n_errors == 0 && n_checks > 0) begin
         $display("Result: passed");
      end else begin
         $display("Result: failed");
      end
      $finish;
   endtask
   ////////////////////////////////////////////////////////////////////////////
   // main sequence
   initial begin
      {psel, penable, pwrite, paddr, pwdata, hold_act, dischg} <= '0;
      meas <= '0;
      repeat (6) @(posedge clock);
      reset <= 1'b0;
      idle(3);
      t_unarmed();
      t_timed();
      t_count();
      t_halt();
      for (int s = 1; s < 5; s++) if (s != 2) t_refuse(s);
      t_lock();
      t_end(32'h6, '{valid: 1'b1, range_settled: 1'b1, pass: 1'b1, default: '0});
      t_end(32'hA, '{valid: 1'b1, range_settled: 1'b1, fail: 1'b1, default: '0});
      t_end(32'h10, '{valid: 1'b1, contact_fail: 1'b1, default: '0});
      t_end(32'h20, '{valid: 1'b1, range_settled: 1'b1, bdd_cnt: 8'h1, default: '0});
      t_end(32'h0, '0);
      tally_and_finish();
   end
   // watchdog sized well past the full sequence
   initial begin
      repeat (60000) @(posedge clock);
      n_errors++;
      tally_and_finish();
   end
endmodule
bind ins_seq ins_seq_properties #(.READY_CNT(READY_CNT)) u_props (
   .CLOCK(CLOCK), .RESET(RESET), .INTERLOCK(INTERLOCK), .EXT_STOP(EXT_STOP),
   .HOLD_ACTIVE(HOLD_ACTIVE), .DISCHARGED(DISCHARGED), .HV_ON(HV_ON),
   .READY_SHOWN(READY_SHOWN), .DELAY_MARK(DELAY_MARK), .TEST_LAMP_DIM(TEST_LAMP_DIM),
   .BEEP(BEEP), .JUDGE_PASS(JUDGE_PASS), .JUDGE_FAIL(JUDGE_FAIL),
   .SHOWN_RESIST(SHOWN_RESIST), .TIMER_SHOWN(TIMER_SHOWN));
